// ==== hdl/ibus_fifo.sv ====
// small fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module ibus_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
    logic          push;
    logic          load;

    assign in_ready_o = count != (AW+1)'(D);
    assign push       = in_valid_i & in_ready_o;
    assign load       = (count != '0) & (~out_valid_o | out_ready_i);

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (load) begin
                rptr <= rptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        end
    end

    // output stage keeps the head in a flop so downstream sees stable data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (load) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rptr];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule // ibus_fifo
`default_nettype wire

// ==== hdl/ibus_iface.sv ====
// instrument bus interface functions: handshakes, addressing, polls, controller
`timescale 1ns/1ps
`default_nettype none
module ibus_iface
    import ibus_pkg::*;
#(
    parameter int unsigned IFC_CYCLES = `IFC_CYCLES
) (
    input  wire logic       CORE_CLK_I,
    input  wire logic       SRST_I,
    input  wire bus_lines_t BUS_I,
    output bus_lines_t      BUS_O,
    output bus_lines_t      BUS_OE_N_O,
    input  wire logic [4:0] MY_ADDR_I,
    input  wire logic [4:0] MY_SEC_I,
    input  wire logic       EXT_EN_I,
    input  wire logic [7:0] STATUS_I,
    input  wire logic       RSV_I,
    input  wire logic       PP_EN_I,
    input  wire logic       PP_SENSE_I,
    input  wire logic [2:0] PP_LINE_I,
    input  wire logic       PP_STATUS_I,
    input  wire logic       SYS_CTRL_I,
    input  wire logic       CTRL_ATN_I,
    input  wire logic       CTRL_IFC_I,
    input  wire logic       CTRL_REN_I,
    input  wire logic       CTRL_PPOLL_I,
    input  wire logic       CTRL_RELEASE_I,
    input  wire logic [7:0] TX_DATA_I,
    input  wire logic       TX_EOI_I,
    input  wire logic       TX_VALID_I,
    output logic            TX_READY_O,
    output logic [7:0]      RX_DATA_O,
    output logic            RX_EOI_O,
    output logic            RX_VALID_O,
    input  wire logic       RX_READY_I,
    output logic            TALK_O,
    output logic            LISTEN_O,
    output logic            REMOTE_O,
    output logic            SPOLL_O,
    output logic            CIC_O,
    output logic            SRQ_PEND_O,
    output logic            CLEAR_O,
    output logic            TRIGGER_O
);
    bus_lines_t sync1;
    bus_lines_t sync2;
    bus_lines_t t;
    bus_lines_t drv;
    ah_state_t  ah;
    sh_state_t  sh;
    settle_t    settle_cnt;
    ifc_cnt_t   ifc_cnt;
    rx_word_t   rx_in;
    rx_word_t   rx_out;
    logic       talk;
    logic       listen;
    logic       lpas;
    logic       tpas;
    logic       spoll;
    logic       remote;
    logic       cic;
    logic       srq_req;
    logic       rsv_q;
    logic       atn_own;
    logic       ifc_own;
    logic [1:0] ifc_echo;
    logic       ah_active;
    logic       room;
    logic       fifo_ready;
    logic       accept;
    logic       pcmd;
    logic       push;
    logic [6:0] cmd;
    logic       is_lag;
    logic       is_tag;
    logic       is_scg;
    logic       mine;
    logic       sec_ok;
    logic       sh_src_ok;
    logic       sp_now;
    logic       sh_sp;
    logic       sh_done;
    logic [7:0] out_byte;
    logic       out_eoi;
    logic       pp_reply;
    logic [7:0] status_byte;

    // raw levels cross into the core clock before anyone looks at them
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            sync1    <= '1;
            sync2    <= '1;
            ifc_echo <= '0;
        end else begin
            sync1    <= BUS_I;
            sync2    <= sync1;
            ifc_echo <= {ifc_echo[0], ifc_own};
        end
    end

    assign t = ~sync2;

    // open-drain style on every line: pull low for true, let go otherwise
    assign BUS_O      = '0;
    assign BUS_OE_N_O = ~drv;

    assign atn_own   = cic & CTRL_ATN_I;
    assign ifc_own   = ifc_cnt != '0;
    assign ah_active = (t.atn & ~atn_own) | (listen & ~t.atn);
    assign room      = t.atn | fifo_ready;
    assign accept    = ah_active & (ah == AH_READY) & t.dav & room;
    assign pcmd      = accept & t.atn;
    assign push      = accept & ~t.atn;
    assign cmd       = t.dio[6:0];
    assign is_lag    = cmd[6:5] == `GRP_LISTEN;
    assign is_tag    = cmd[6:5] == `GRP_TALK;
    assign is_scg    = cmd[6:5] == `GRP_SECOND;
    assign mine      = cmd[4:0] == MY_ADDR_I;
    assign sec_ok    = cmd[4:0] == MY_SEC_I;

    // acceptor: READY lets NRFD go only with room, HOLD lets NDAC go
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || t.ifc || !ah_active) begin
            ah <= AH_IDLE;
        end else begin
            unique case (ah)
                AH_IDLE: begin
                    ah <= AH_READY;
                end
                AH_READY: begin
                    if (accept) begin
                        ah <= AH_HOLD;
                    end
                end
                AH_HOLD: begin
                    if (!t.dav) begin
                        ah <= AH_READY;
                    end
                end
            endcase
        end
    end

    assign rx_in.eoi  = t.eoi;
    assign rx_in.data = t.dio;

    ibus_fifo #(
        .W ($bits(rx_word_t)),
        .D (`FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_i       (SRST_I),
        .in_valid_i  (push),
        .in_data_i   (rx_in),
        .in_ready_o  (fifo_ready),
        .out_valid_o (RX_VALID_O),
        .out_data_o  (rx_out),
        .out_ready_i (RX_READY_I)
    );

    assign RX_DATA_O = rx_out.data;
    assign RX_EOI_O  = rx_out.eoi;

    // listen addressing, basic or with secondary
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || t.ifc) begin
            listen <= 1'b0;
            lpas   <= 1'b0;
        end else if (pcmd) begin
            if (cmd == `CMD_UNL) begin
                listen <= 1'b0;
            end else if (is_lag && mine && !EXT_EN_I) begin
                listen <= 1'b1;
            end else if (is_scg && lpas && sec_ok) begin
                listen <= 1'b1;
            end
            if (!is_scg) begin
                lpas <= is_lag & mine & EXT_EN_I;
            end
        end
    end

    // talk addressing: any other talk address or untalk drops us
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || t.ifc) begin
            talk <= 1'b0;
            tpas <= 1'b0;
        end else if (pcmd) begin
            if (is_tag) begin
                talk <= mine & ~EXT_EN_I;
            end else if (is_scg && tpas && sec_ok) begin
                talk <= 1'b1;
            end
            if (!is_scg) begin
                tpas <= is_tag & mine & EXT_EN_I;
            end
        end
    end

    // serial poll mode is universal
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || t.ifc) begin
            spoll <= 1'b0;
        end else if (pcmd && cmd == `CMD_SPE) begin
            spoll <= 1'b1;
        end else if (pcmd && cmd == `CMD_SPD) begin
            spoll <= 1'b0;
        end
    end

    // clear and trigger pulses; group forms only reach addressed listeners
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            CLEAR_O   <= 1'b0;
            TRIGGER_O <= 1'b0;
        end else begin
            CLEAR_O   <= pcmd & ((cmd == `CMD_DCL) | (listen & (cmd == `CMD_SDC)));
            TRIGGER_O <= pcmd & listen & (cmd == `CMD_GET);
        end
    end

    // remote follows REN; go-to-local only from an addressed listener
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || !t.ren) begin
            remote <= 1'b0;
        end else if (pcmd && is_lag && mine) begin
            remote <= 1'b1;
        end else if (pcmd && listen && cmd == `CMD_GTL) begin
            remote <= 1'b0;
        end
    end

    // controller in charge: foreign IFC idles us, our own IFC echo through the syncs does not
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            cic <= 1'b0;
        end else if (ifc_own) begin
            cic <= 1'b1;
        end else if (t.ifc && ifc_echo == '0) begin
            cic <= 1'b0;
        end else if (pcmd && talk && cmd == `CMD_TCT) begin
            cic <= 1'b1;
        end else if (CTRL_RELEASE_I && !CTRL_ATN_I) begin
            cic <= 1'b0;
        end
    end

    // IFC length is a long count; the parameter lets a bench shorten it
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ifc_cnt <= '0;
        end else if (CTRL_IFC_I && SYS_CTRL_I && !ifc_own) begin
            ifc_cnt <= ifc_cnt_t'(IFC_CYCLES);
        end else if (ifc_own) begin
            ifc_cnt <= ifc_cnt - 1'b1;
        end
    end

    // service request; a new request in the cycle of the read wins
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            rsv_q   <= 1'b0;
            srq_req <= 1'b0;
        end else begin
            rsv_q <= RSV_I;
            if (RSV_I && !rsv_q) begin
                srq_req <= 1'b1;
            end else if (sh_done && sh_sp && out_byte[`RQS_BIT]) begin
                srq_req <= 1'b0;
            end
        end
    end

    assign status_byte = {STATUS_I[7], srq_req, STATUS_I[5:0]};
    assign sh_src_ok   = atn_own | (talk & ~t.atn);
    assign sp_now      = spoll & talk & ~atn_own;
    assign sh_done     = (sh == SH_DAV) & ~t.ndac & sh_src_ok;

    // source: settle, wait for every acceptor ready, DAV, wait accepted
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || t.ifc || !sh_src_ok) begin
            sh         <= SH_IDLE;
            settle_cnt <= '0;
            sh_sp      <= 1'b0;
            out_byte   <= '0;
            out_eoi    <= 1'b0;
        end else begin
            unique case (sh)
                SH_IDLE: begin
                    if (sp_now || TX_VALID_I) begin
                        sh         <= SH_SETTLE;
                        settle_cnt <= settle_t'(`SETTLE_CYCLES);
                        sh_sp      <= sp_now;
                        out_byte   <= sp_now ? status_byte : TX_DATA_I;
                        out_eoi    <= ~sp_now & TX_EOI_I & ~atn_own;
                    end
                end
                SH_SETTLE: begin
                    if (settle_cnt != '0) begin
                        settle_cnt <= settle_cnt - 1'b1;
                    end else if (!t.nrfd) begin
                        sh <= SH_DAV;
                    end
                end
                SH_DAV: begin
                    if (!t.ndac) begin
                        sh <= SH_IDLE;
                    end
                end
            endcase
        end
    end

    assign TX_READY_O = sh_done & ~sh_sp;
    assign pp_reply   = t.atn & t.eoi & ~atn_own & PP_EN_I & (PP_STATUS_I == PP_SENSE_I);

    // each data line carries the sourced byte or the poll reply bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dio
            assign drv.dio[gi] = ((sh != SH_IDLE) & out_byte[gi]) | (pp_reply & (PP_LINE_I == 3'(gi)));
        end
    endgenerate

    assign drv.dav  = sh == SH_DAV;
    assign drv.nrfd = ah_active & ~((ah == AH_READY) & room);
    assign drv.ndac = ah_active & (ah != AH_HOLD);
    assign drv.atn  = atn_own;
    assign drv.eoi  = ((sh != SH_IDLE) & out_eoi) | (atn_own & CTRL_PPOLL_I);
    assign drv.srq  = srq_req;
    assign drv.ifc  = ifc_own;
    assign drv.ren  = SYS_CTRL_I & CTRL_REN_I;

    assign TALK_O     = talk;
    assign LISTEN_O   = listen;
    assign REMOTE_O   = remote;
    assign SPOLL_O    = spoll;
    assign CIC_O      = cic;
    assign SRQ_PEND_O = srq_req;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SRST_I);

    sequence s_settled;
        (sh == SH_SETTLE) && (settle_cnt == '0) && !t.nrfd;
    endsequence

    sequence s_dav_up;
        ##1 (sh == SH_DAV);
    endsequence

    dav_interlock_a: assert property ((sh == SH_SETTLE) ##1 (sh == SH_DAV) |-> $past(settle_cnt == '0) && $past(!t.nrfd))
        else $error("dav raised before settle and ready");
    settle_to_dav_a: assert property ((s_settled and (sh_src_ok && !t.ifc)) |-> s_dav_up)
        else $error("settled source did not raise dav");
    accept_holdoff_a: assert property ((ah == AH_READY) && ah_active && !room |-> drv.nrfd)
        else $error("acceptor released nrfd with no room");
    ifc_unaddress_a: assert property (t.ifc |=> !talk && !listen && !spoll)
        else $error("addressing kept through ifc");
    atn_stops_source_a: assert property (t.atn && !atn_own |=> sh == SH_IDLE)
        else $error("source kept running under foreign atn");
    ctrl_atn_only_a: assert property (drv.atn |-> cic)
        else $error("atn driven while not in charge");
    sysctl_lines_a: assert property (drv.ifc || drv.ren |-> SYS_CTRL_I)
        else $error("ifc or ren driven by non system controller");
    srq_release_a: assert property ($fell(srq_req) |-> $past(sh_done && sh_sp))
        else $error("srq dropped without status read");
    poll_reply_a: assert property (pp_reply |-> drv.dio[PP_LINE_I])
        else $error("parallel poll reply missing");
    data_listen_a: assert property (push |-> listen && !t.atn)
        else $error("data taken while not listening");
    talk_data_a: assert property ((sh == SH_DAV) && !atn_own |-> talk)
        else $error("data sourced while not talking");
endmodule // ibus_iface
`default_nettype wire

// ==== hdl/ibus_map.svh ====
// register-free constants, command codes and timing counts for the instrument bus block
// How it works
// - handshake and service lines only pulled, wired-OR
// - low level true, high level false
// - source interlocks DAV with ready and accepted
// - acceptor holds off start or end
// - talk data only when addressed; poll sends status
// - talk address: one byte or two bytes
// - listen data only when addressed; one/two bytes
// - SRQ mirrors request bit, drops once read
// - remote or local follows REN
// - poll reply driven without talk addressing
// - clear alone or as addressed group
// - trigger only as addressed group
// - controller commands only while driving ATN
// - one controller in charge, others idle
// - system controller may drive IFC, REN anytime
// - ATN stops activity, everyone listens
// - IFC idles interface, drops all addressing
// - EOI ends string; EOI with ATN polls
// - ATN false data, ATN true command
// - universal always, addressed only when listening; TCT acts only when talking
// - address sets roles, unaddress drops them
// - handshake lines are DAV, NRFD, NDAC
`ifndef IBUS_MAP_SVH
`define IBUS_MAP_SVH
`define CLK_NS        4
`define SETTLE_NS     2000
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_W      10
`define IFC_NS        100000
`define IFC_CYCLES    ((`IFC_NS + `CLK_NS - 1) / `CLK_NS)
`define IFC_W         15
`define FIFO_DEPTH    8
`define CMD_GTL       7'h01
`define CMD_SDC       7'h04
`define CMD_GET       7'h08
`define CMD_TCT       7'h09
`define CMD_DCL       7'h14
`define CMD_SPE       7'h18
`define CMD_SPD       7'h19
`define CMD_UNL       7'h3f
`define GRP_LISTEN    2'h1
`define GRP_TALK      2'h2
`define GRP_SECOND    2'h3
`define RQS_BIT       6
`endif

// ==== hdl/ibus_pkg.sv ====
// types shared by the instrument bus block
`include "ibus_map.svh"
package ibus_pkg;
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       atn;
        logic       eoi;
        logic       srq;
        logic       ifc;
        logic       ren;
    } bus_lines_t;
    typedef struct packed {
        logic       eoi;
        logic [7:0] data;
    } rx_word_t;
    typedef logic [`SETTLE_W-1:0] settle_t;
    typedef logic [`IFC_W-1:0]    ifc_cnt_t;
    typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_HOLD} ah_state_t;
    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV} sh_state_t;
endpackage

// ==== sim/ibus_far.sv ====
// far-side model of the bus: controller in charge plus one other instrument
`timescale 1ns/1ps
`default_nettype none
module ibus_far
    import ibus_pkg::*;
(
    input  wire logic       clk_i,
    input  wire bus_lines_t lvl_i,
    output bus_lines_t      pull_o
);
    localparam int DAV_B  = 7;
    localparam int NRFD_B = 6;
    localparam int NDAC_B = 5;
    localparam int SETTLE = 8;
    int errs = 0;
    int hold = 0;
    // a one pulls the line low; released lines float up to the termination
    initial pull_o = '0;
    // bounded wait until line b reads truth value v (low level is true)
    task automatic wait_is(input int b, input logic v);
        int n;
        n = 0;
        while (lvl_i[b] !== ~v && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 4000) errs++;
    endtask
    // single-line messages; this side is controller until the block takes charge, so until then ATN, IFC and REN come from here
    task automatic line(input int b, input logic v);
        @(posedge clk_i);
        pull_o[b] <= v;
    endtask
    task automatic listen(input logic on);
        @(posedge clk_i);
        pull_o.nrfd <= on;
        pull_o.ndac <= on;
    endtask
    // short settle keeps this source quicker than the block
    task automatic send(input logic [7:0] d, input logic e);
        @(posedge clk_i);
        pull_o.dio <= d;
        pull_o.eoi <= e;
        repeat (SETTLE) @(posedge clk_i);
        wait_is(NRFD_B, 1'b0);
        pull_o.dav <= 1'b1;
        wait_is(NDAC_B, 1'b0);
        @(posedge clk_i);
        pull_o.dav <= 1'b0;
        pull_o.dio <= 8'h00;
        pull_o.eoi <= 1'b0;
    endtask
    // hold lets the acceptor be slow before it admits readiness
    task automatic recv(output logic [7:0] d, output logic e);
        repeat (hold + 1) @(posedge clk_i);
        pull_o.nrfd <= 1'b0;
        wait_is(DAV_B, 1'b1);
        d = ~lvl_i.dio;
        e = ~lvl_i.eoi;
        pull_o.nrfd <= 1'b1;
        pull_o.ndac <= 1'b0;
        wait_is(DAV_B, 1'b0);
        pull_o.ndac <= 1'b1;
    endtask
endmodule // ibus_far
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the instrument bus block
`include "ibus_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ibus_pkg::*;
    localparam int         IFC_N = 20;  // short clear pulse keeps the run brief
    localparam int         REN_B = 0;
    localparam int         IFC_B = 1;
    localparam int         EOI_B = 3;
    localparam int         ATN_B = 4;
    localparam logic [4:0] ADDR  = 5'h0b;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    bus_lines_t oe_n;
    bus_lines_t far;
    bus_lines_t lvl;
    bus_lines_t pins;
    logic [4:0] sec = 5'h03;
    logic       ext = 1'b0;
    logic [7:0] status = 8'h25;
    logic       rsv = 1'b0;
    logic       pp_en = 1'b0;
    logic [2:0] pp_line = 3'h0;
    logic       pp_stat = 1'b1;
    logic       pp_sense = 1'b1;
    logic       c_ppoll = 1'b0;
    logic       c_rel = 1'b0;
    logic       sysc = 1'b0;
    logic       c_atn = 1'b0;
    logic       c_ifc = 1'b0;
    logic       c_ren = 1'b0;
    logic [7:0] tx_d = 8'h00;
    logic       tx_e = 1'b0;
    logic       tx_v = 1'b0;
    logic       rx_rdy = 1'b1;
    logic       tx_rdy, rx_e, rx_v, talk, lsn, rem, spoll, cic, srqp, clr, trg;
    logic [7:0] rx_d;
    int         fail_count = 0;
    int         num_checks = 0;
    int         clears = 0;
    int         trigs = 0;
    rx_word_t   rxq[$];
    logic [7:0] dat[3] = '{8'h14, 8'h3f, 8'h5a};
    logic [6:0] cmds[7] = '{`CMD_SDC, `CMD_GET, `CMD_GTL, `CMD_UNL, `CMD_SDC, `CMD_GET, `CMD_DCL};
    logic [1:0] exp_ct[7] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

    // wired lines: any party pulling makes the line low, i.e. true
    assign lvl = ~((~oe_n & ~pins) | far);

    initial forever #2 clk = ~clk;

    ibus_iface #(.IFC_CYCLES(IFC_N)) u_dut (
        .CORE_CLK_I(clk), .SRST_I(rst), .BUS_I(lvl), .BUS_O(pins), .BUS_OE_N_O(oe_n),
        .MY_ADDR_I(ADDR), .MY_SEC_I(sec), .EXT_EN_I(ext), .STATUS_I(status), .RSV_I(rsv),
        .PP_EN_I(pp_en), .PP_SENSE_I(pp_sense), .PP_LINE_I(pp_line), .PP_STATUS_I(pp_stat),
        .SYS_CTRL_I(sysc), .CTRL_ATN_I(c_atn), .CTRL_IFC_I(c_ifc), .CTRL_REN_I(c_ren),
        .CTRL_PPOLL_I(c_ppoll), .CTRL_RELEASE_I(c_rel), .TX_DATA_I(tx_d), .TX_EOI_I(tx_e),
        .TX_VALID_I(tx_v), .TX_READY_O(tx_rdy), .RX_DATA_O(rx_d), .RX_EOI_O(rx_e),
        .RX_VALID_O(rx_v), .RX_READY_I(rx_rdy), .TALK_O(talk), .LISTEN_O(lsn), .REMOTE_O(rem),
        .SPOLL_O(spoll), .CIC_O(cic), .SRQ_PEND_O(srqp), .CLEAR_O(clr), .TRIGGER_O(trg)
    );
    ibus_far u_far (.clk_i(clk), .lvl_i(lvl), .pull_o(far));

    always @(posedge clk) begin
        if (rx_v === 1'b1 && rx_rdy === 1'b1) rxq.push_back({rx_e, rx_d});
        if (clr === 1'b1) clears++;
        if (trg === 1'b1) trigs++;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic see_rx(input logic [8:0] w);
        chk("rx word", {7'h00, w}, rxq.size() > 0 ? {7'h00, rxq.pop_front()} : 16'hxxxx);
    endtask
    task automatic done(input string name);
        $display("test %s done", name);
    endtask
    // block sources one byte, far side accepts it
    task automatic tx_and_see(input logic [7:0] d, input logic e);
        logic [7:0] got;
        logic       ge;
        int         n;
        fork
            u_far.recv(got, ge);
            begin
                @(posedge clk);
                tx_d <= d;
                tx_e <= e;
                tx_v <= 1'b1;
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (tx_rdy !== 1'b1 && n < 5000);
                tx_v <= 1'b0;
            end
        join
        chk("tx byte", {7'h00, e, d}, {7'h00, ge, got});
    endtask
    task automatic end_sim();
        fail_count += u_far.errs;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        logic [7:0] g;
        logic       ge;
        int         c0;
        int         t0;
        int         n;
        repeat (12) @(posedge clk);
        chk("enables in reset", 16'hffff, oe_n);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        u_far.line(REN_B, 1'b1);
        u_far.line(ATN_B, 1'b1);
        u_far.send({1'b0, `GRP_LISTEN, ADDR}, 1'b0);
        repeat (4) @(posedge clk);
        chk("listen flag", 1, lsn);
        chk("remote flag", 1, rem);
        u_far.line(ATN_B, 1'b0);
        foreach (dat[i]) u_far.send(dat[i], i == 2);
        repeat (8) @(posedge clk);
        foreach (dat[i]) see_rx({i == 2, dat[i]});
        chk("clear on data", 0, clears);
        done("listen");
        // fifo plus output register take nine, the tenth must be held off
        rx_rdy <= 1'b0;
        for (int i = 0; i < 9; i++) u_far.send(8'h30 + i[7:0], 1'b0);
        fork
            u_far.send(8'h39, 1'b1);
            begin
                repeat (300) @(posedge clk);
                chk("held ready line", 0, lvl.nrfd);
                chk("valid not raised", 0, far.dav);
                rx_rdy <= 1'b1;
            end
        join
        repeat (20) @(posedge clk);
        for (int i = 0; i < 10; i++) see_rx({i == 9, 8'h30 + i[7:0]});
        done("hold-off");
        u_far.line(ATN_B, 1'b1);
        foreach (cmds[i]) begin
            c0 = clears;
            t0 = trigs;
            u_far.send({1'b0, cmds[i]}, 1'b0);
            repeat (4) @(posedge clk);
            chk("clear count", exp_ct[i][1], clears - c0);
            chk("trigger count", exp_ct[i][0], trigs - t0);
        end
        chk("listen after unlisten", 0, lsn);
        chk("remote after local", 0, rem);
        u_far.line(ATN_B, 1'b0);
        u_far.send(8'h77, 1'b0);
        repeat (8) @(posedge clk);
        chk("unaddressed data", 0, rxq.size());
        done("commands");
        rsv <= 1'b1;
        repeat (8) @(posedge clk);
        chk("srq pulled", 0, oe_n.srq);
        chk("srq pending", 1, srqp);
        u_far.line(ATN_B, 1'b1);
        u_far.send({1'b0, `CMD_SPE}, 1'b0);
        u_far.send({1'b0, `GRP_TALK, ADDR}, 1'b0);
        repeat (4) @(posedge clk);
        chk("talk flag", 1, talk);
        chk("poll flag", 1, spoll);
        u_far.listen(1'b1);
        u_far.line(ATN_B, 1'b0);
        u_far.recv(g, ge);
        chk("status byte", status | (8'h01 << `RQS_BIT), g);
        repeat (8) @(posedge clk);
        chk("srq after read", 1, oe_n.srq);
        chk("pending after read", 0, srqp);
        u_far.line(ATN_B, 1'b1);
        u_far.listen(1'b0);
        u_far.send({1'b0, `CMD_SPD}, 1'b0);
        u_far.listen(1'b1);
        u_far.line(ATN_B, 1'b0);
        u_far.hold = 600;
        tx_and_see(8'hc3, 1'b1);
        done("serial poll");
        u_far.listen(1'b0);
        u_far.line(IFC_B, 1'b1);
        repeat (30) @(posedge clk);
        u_far.line(IFC_B, 1'b0);
        repeat (4) @(posedge clk);
        chk("roles after clear", 0, {talk, lsn, spoll});
        chk("enables after clear", 16'hffff, oe_n);
        // unaddressed device still answers the poll on its own line
        pp_en <= 1'b1;
        u_far.line(ATN_B, 1'b1);
        u_far.line(EOI_B, 1'b1);
        for (int i = 0; i < 9; i++) begin
            pp_line <= i[2:0];
            pp_sense <= i[0];
            pp_stat <= i[0] ^ (i == 8);
            repeat (52) @(posedge clk);
            chk("poll reply", {8'h00, i < 8 ? ~(8'h01 << i) : 8'hff}, {8'h00, oe_n.dio});
        end
        u_far.line(EOI_B, 1'b0);
        done("parallel poll");
        ext <= 1'b1;
        u_far.send({1'b0, `GRP_TALK, ADDR}, 1'b0);
        repeat (4) @(posedge clk);
        chk("primary only", 0, talk);
        u_far.send({1'b0, `GRP_SECOND, sec}, 1'b0);
        repeat (4) @(posedge clk);
        chk("primary and secondary", 1, talk);
        u_far.line(ATN_B, 1'b0);
        done("extended");
        sysc <= 1'b1;
        c_ren <= 1'b1;
        c_atn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("ren driven", 0, oe_n.ren);
        chk("atn without charge", 1, oe_n.atn);
        c_ifc <= 1'b1;
        @(posedge clk);
        c_ifc <= 1'b0;
        n = 0;
        repeat (IFC_N + 40) begin
            @(posedge clk);
            n += (oe_n.ifc === 1'b0);
        end
        chk("ifc long enough", 1, n >= IFC_N);
        chk("in charge", 1, cic);
        chk("atn driven", 0, oe_n.atn);
        u_far.listen(1'b1);
        tx_and_see({1'b0, `CMD_UNL}, 1'b0);
        c_ppoll <= 1'b1;
        repeat (4) @(posedge clk);
        chk("eoi with own atn", 0, oe_n.eoi);
        c_ppoll <= 1'b0;
        c_atn <= 1'b0;
        c_rel <= 1'b1;
        repeat (4) @(posedge clk);
        chk("charge released", 0, cic);
        done("controller");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
